// >>> design/multipurpose_pin_config.sv
// Purpose: Configuration and live readback of multipurpose pins 1 to 4.
// Assumes: Single-cycle byte register port; pad handles analog resistors.
// Notes: Read data is registered and appears one cycle after the strobe.
// Contract
// - Direction bit 2 at 0 gives a high-impedance input, at 1 drives.
// - Out value bit 4 at 0 pulls low, at 1 releases or drives high.
// - Value and drive-type bits act only while the direction is output.
// - Drive-type bit 3 selects push-pull at 0 and open drain at 1.
// - Resistor bit 1 attaches a resistor, and only while the pin is an input.
// - Pull bit 0 picks pull-down at 0 and pull-up at 1 with a resistor.
// - Read-only bit 7 gives the live pin level, high when released.
`timescale 1ns/10ps
module multipurpose_pin_config #(
  parameter int NUM_PINS = mpin_pkg::NUM_PINS
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  output logic [NUM_PINS-1:0] o_pin_rail_drive,
  output logic [NUM_PINS-1:0] o_pin_pull_up_en,
  output logic [NUM_PINS-1:0] o_pin_pull_down_en,
  output logic [NUM_PINS-1:0] o_pin_input_en
);
  logic [7:0] config_r [NUM_PINS];
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] wr_hit;
  logic [NUM_PINS-1:0] rd_sel;

  function automatic logic [NUM_PINS-1:0] decode(input logic [7:0] addr);
    logic [NUM_PINS-1:0] sel;
    sel = '0;
    for (int k = 0; k < NUM_PINS; k++) begin
      if (addr == 8'(mpin_pkg::PIN1_CONFIG_OFS + k)) begin
        sel[k] = 1'b1;
      end
    end
    return sel;
  endfunction

  assign wr_hit = i_reg_wr ? decode(i_reg_addr) : '0;
  assign rd_sel = decode(i_reg_addr);

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_sync
    pin_level_sync u_sync (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_ce(i_ce),
      .i_pin(i_pin_in[g]),
      .o_level(pin_level[g])
    );
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        config_r[k] <= mpin_pkg::CONFIG_RESET;
      end
    end else if (i_ce) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        if (wr_hit[k]) begin
          config_r[k] <= i_reg_wdata & mpin_pkg::CONFIG_WMASK;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata <= mpin_pkg::READ_FILL;
      o_reg_hit <= 1'b0;
    end else if (i_ce) begin
      o_reg_hit <= (i_reg_rd || i_reg_wr) && (rd_sel != '0);
      o_reg_rdata <= mpin_pkg::READ_FILL;
      if (i_reg_rd) begin
        for (int k = 0; k < NUM_PINS; k++) begin
          if (rd_sel[k]) begin
            o_reg_rdata <= config_r[k] & mpin_pkg::CONFIG_WMASK;
            o_reg_rdata[mpin_pkg::PIN_LEVEL_BIT] <= pin_level[k];
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
      o_pin_rail_drive <= '0;
      o_pin_pull_up_en <= '0;
      o_pin_pull_down_en <= '0;
      o_pin_input_en <= '1;
    end else if (i_ce) begin
      for (int k = 0; k < NUM_PINS; k++) begin
        // Output side: value and drive type matter only when driving.
        if (config_r[k][mpin_pkg::DIRECTION_BIT]) begin
          o_pin_out[k] <= 1'b0;
          o_pin_input_en[k] <= 1'b0;
          o_pin_pull_up_en[k] <= 1'b0;
          o_pin_pull_down_en[k] <= 1'b0;
          if (!config_r[k][mpin_pkg::OUT_VALUE_BIT]) begin
            o_pin_oe[k] <= 1'b1;
            o_pin_rail_drive[k] <= 1'b0;
          end else if (config_r[k][mpin_pkg::DRIVE_TYPE_BIT]) begin
            o_pin_oe[k] <= 1'b0;
            o_pin_rail_drive[k] <= 1'b0;
          end else begin
            o_pin_oe[k] <= 1'b1;
            o_pin_out[k] <= 1'b1;
            o_pin_rail_drive[k] <= 1'b1;
          end
        end else begin
          o_pin_oe[k] <= 1'b0;
          o_pin_out[k] <= 1'b0;
          o_pin_rail_drive[k] <= 1'b0;
          o_pin_input_en[k] <= 1'b1;
          o_pin_pull_up_en[k] <=
              config_r[k][mpin_pkg::RESISTOR_PRESENT_BIT] &&
              config_r[k][mpin_pkg::PULL_SELECT_BIT];
          o_pin_pull_down_en[k] <=
              config_r[k][mpin_pkg::RESISTOR_PRESENT_BIT] &&
              !config_r[k][mpin_pkg::PULL_SELECT_BIT];
        end
      end
    end
  end

  // Assertions.
  property p_input_mode_hiz;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && !config_r[0][mpin_pkg::DIRECTION_BIT] |=>
      !o_pin_oe[0] && o_pin_input_en[0];
  endproperty
  a_input_mode_hiz: assert property (p_input_mode_hiz)
    else $error("Input-mode pin is driven.");
  property p_input_hiz_pin2;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && !config_r[1][mpin_pkg::DIRECTION_BIT] |=>
      !o_pin_oe[1] && o_pin_input_en[1];
  endproperty
  a_input_hiz_pin2: assert property (p_input_hiz_pin2)
    else $error("Input-mode pin 2 is driven.");
  property p_output_no_input;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && config_r[0][mpin_pkg::DIRECTION_BIT] |=>
      !o_pin_input_en[0];
  endproperty
  a_output_no_input: assert property (p_output_no_input)
    else $error("Input buffer on in output mode.");
  property p_low_drive;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && config_r[0][mpin_pkg::DIRECTION_BIT] &&
      !config_r[0][mpin_pkg::OUT_VALUE_BIT] |=>
      o_pin_oe[0] && !o_pin_out[0];
  endproperty
  a_low_drive: assert property (p_low_drive)
    else $error("Low output not driven to ground.");
  property p_ignore_in_input;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && !config_r[0][mpin_pkg::DIRECTION_BIT] |=>
      !o_pin_rail_drive[0] && !o_pin_out[0];
  endproperty
  a_ignore_in_input: assert property (p_ignore_in_input)
    else $error("Drive bits act in input mode.");
  property p_open_drain;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && config_r[0][mpin_pkg::DIRECTION_BIT] &&
      config_r[0][mpin_pkg::OUT_VALUE_BIT] &&
      config_r[0][mpin_pkg::DRIVE_TYPE_BIT] |=>
      !o_pin_oe[0] && !o_pin_rail_drive[0];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain high is driven.");
  property p_push_pull_high;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && config_r[0][mpin_pkg::DIRECTION_BIT] &&
      config_r[0][mpin_pkg::OUT_VALUE_BIT] &&
      !config_r[0][mpin_pkg::DRIVE_TYPE_BIT] |=>
      o_pin_oe[0] && o_pin_out[0] && o_pin_rail_drive[0];
  endproperty
  a_push_pull_high: assert property (p_push_pull_high)
    else $error("Push-pull high not driven to the rail.");
  property p_no_pull_output;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && config_r[0][mpin_pkg::DIRECTION_BIT] |=>
      !o_pin_pull_up_en[0] && !o_pin_pull_down_en[0];
  endproperty
  a_no_pull_output: assert property (p_no_pull_output)
    else $error("Resistor attached in output mode.");
  property p_pull_up_select;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && !config_r[0][mpin_pkg::DIRECTION_BIT] &&
      config_r[0][mpin_pkg::RESISTOR_PRESENT_BIT] &&
      config_r[0][mpin_pkg::PULL_SELECT_BIT] |=>
      o_pin_pull_up_en[0] && !o_pin_pull_down_en[0];
  endproperty
  a_pull_up_select: assert property (p_pull_up_select)
    else $error("Pull-up not selected.");
  property p_pull_down_select;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && !config_r[0][mpin_pkg::DIRECTION_BIT] &&
      config_r[0][mpin_pkg::RESISTOR_PRESENT_BIT] &&
      !config_r[0][mpin_pkg::PULL_SELECT_BIT] |=>
      o_pin_pull_down_en[0] && !o_pin_pull_up_en[0];
  endproperty
  a_pull_down_select: assert property (p_pull_down_select)
    else $error("Pull-down not selected.");
  property p_pull_exclusive;
    @(posedge i_ref_clk) disable iff (i_srst)
      !(o_pin_pull_up_en[0] && o_pin_pull_down_en[0]);
  endproperty
  a_pull_exclusive: assert property (p_pull_exclusive)
    else $error("Pull-up and pull-down both on.");
  property p_level_read;
    @(posedge i_ref_clk) disable iff (i_srst)
      i_ce && i_reg_rd && rd_sel[0] |=>
      o_reg_rdata[mpin_pkg::PIN_LEVEL_BIT] == $past(pin_level[0]);
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("Pin level bit wrong.");
  property p_unused_zero;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_reg_rdata[6:5] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Unused bits not zero.");
  property p_ce_freeze;
    @(posedge i_ref_clk) disable iff (i_srst)
      !i_ce |=> $stable(config_r[0]) && $stable(o_pin_oe) &&
      $stable(o_reg_rdata);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("State moved while the clock enable is low.");
  c_write: cover property (@(posedge i_ref_clk) i_ce && wr_hit != '0);
  c_push_pull: cover property (@(posedge i_ref_clk) o_pin_rail_drive[0]);
  c_pull_up: cover property (@(posedge i_ref_clk) o_pin_pull_up_en[0]);
  c_open_drain: cover property (@(posedge i_ref_clk)
    config_r[0][mpin_pkg::DIRECTION_BIT] && !o_pin_oe[0]);
  c_ce_low: cover property (@(posedge i_ref_clk) !i_ce && i_reg_wr);
endmodule

// >>> design/pin_level_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: The pin is asynchronous to i_ref_clk.
// Notes: The level moves only when stages two and three agree.
`timescale 1ns/10ps
module pin_level_sync (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] stage_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      stage_r <= 3'h0;
    end else if (i_ce) begin
      stage_r <= {stage_r[1:0], i_pin};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_level <= 1'b0;
    end else if (i_ce && (stage_r[1] == stage_r[2])) begin
      o_level <= stage_r[2];
    end
  end
endmodule

// >>> shared/mpin_pkg.sv
// Purpose: Constants for the multipurpose pin configuration block.
// Assumes: Byte-wide registers reached by a simple register port.
// Notes: Offsets are the register addresses of pins 1 to 4.
package mpin_pkg;
  localparam int NUM_PINS = 4;
  localparam logic [7:0] PIN1_CONFIG_OFS = 8'h73;
  localparam logic [7:0] PIN2_CONFIG_OFS = 8'h74;
  localparam logic [7:0] PIN3_CONFIG_OFS = 8'h75;
  localparam logic [7:0] PIN4_CONFIG_OFS = 8'h76;
  localparam int PULL_SELECT_BIT = 0;
  localparam int RESISTOR_PRESENT_BIT = 1;
  localparam int DIRECTION_BIT = 2;
  localparam int DRIVE_TYPE_BIT = 3;
  localparam int OUT_VALUE_BIT = 4;
  localparam int PIN_LEVEL_BIT = 7;
  localparam logic [7:0] CONFIG_WMASK = 8'h1f;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_FILL = 8'h00;
endpackage

// >>> verification/multipurpose_pin_config_tb.sv
// Purpose: Self-checking bench for the multipurpose pin block.
// Assumes: Register accesses follow the one-cycle strobe port.
// Notes: Expected values come from a register model in the bench.
`timescale 1ns/10ps
module multipurpose_pin_config_tb;
  logic clk = 0, srst = 1, ce = 1, wr = 0, rd = 0, hit;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] cfg[4];
  logic [3:0] pin, pout, oe, rail, pu, pd, ie;
  logic [3:0] ext_en = 4'h0, ext_val = 4'h0;
  logic [31:0] seed = 32'h0000_68ca;
  int failures = 0, checked = 0;
  multipurpose_pin_config dut (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_hit(hit), .i_pin_in(pin), .o_pin_out(pout),
    .o_pin_oe(oe), .o_pin_rail_drive(rail), .o_pin_pull_up_en(pu),
    .o_pin_pull_down_en(pd), .o_pin_input_en(ie));
  pin_world far (.i_oe(oe), .i_out(pout), .i_pd(pd), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(pin));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic lvl(input logic [7:0] c, input int p);
    if (c[2]) return c[4] & (~c[3] | ~ext_en[p] | ext_val[p]);
    return ext_en[p] ? ext_val[p] : ~(c[1] & ~c[0]);
  endfunction
  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic pad_chk();
    logic d;
    logic [15:0] e, g;
    for (int p = 0; p < 4; p++) begin
      d = cfg[p][2];
      e = {10'h000, d & ~(cfg[p][4] & cfg[p][3]), d & cfg[p][4] & ~cfg[p][3],
        d & cfg[p][4] & ~cfg[p][3], ~d & cfg[p][1] & cfg[p][0],
        ~d & cfg[p][1] & ~cfg[p][0], ~d};
      g = {10'h000, oe[p], oe[p] & pout[p], rail[p], pu[p], pd[p], ie[p]};
      cmp(e, g);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input int p);
    logic [15:0] e;
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    e = 16'h0000;
    if (p >= 0) e = {7'h00, 1'b1, lvl(cfg[p], p), 2'b00, cfg[p][4:0]};
    cmp(e, {7'h00, hit, rdata});
  endtask
  task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
    logic m;
    m = a inside {[8'h73:8'h76]};
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (m) cfg[a - 8'h73] = d & mpin_pkg::CONFIG_WMASK;
    #1;
    cmp({15'h0000, m}, {15'h0000, hit});
  endtask
  task automatic ce_chk();
    @(posedge clk);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= mpin_pkg::PIN1_CONFIG_OFS;
    wdata <= ~cfg[0];
    repeat (3) @(posedge clk);
    wr <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    #1;
    pad_chk();
    rd_chk(mpin_pkg::PIN1_CONFIG_OFS, 0);
  endtask
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (cfg[i]) cfg[i] = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    pad_chk();
    for (int i = 0; i < 4; i++) rd_chk(8'(8'h73 + i), i);
  endtask
  initial begin
    do_reset();
    rd_chk(8'h72, -1);
    rd_chk(8'h77, -1);
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      ext_en <= seed[11:8];
      ext_val <= seed[15:12];
      wr_cfg(8'h73 + 8'(seed[1:0]), seed[23:16]);
      @(posedge clk);
      #1;
      pad_chk();
      repeat (6) @(posedge clk);
      rd_chk(8'h73 + 8'(seed[1:0]), seed[1:0]);
    end
    ce_chk();
    wr_cfg(8'h77, 8'h14);
    @(posedge clk);
    #1;
    pad_chk();
    do_reset();
    finish_test();
  end
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule

// >>> verification/pin_world.sv
// Purpose: External circuitry attached to the four multipurpose pins.
// Assumes: A board pull-up holds an undriven pin high unless the pad pull-down is on.
// Notes: The bench may switch on an outside driver per pin.
`timescale 1ns/10ps
module pin_world (
  input wire logic [3:0] i_oe,
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_pd,
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_val,
  output logic [3:0] o_level
);
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      if (i_oe[p]) begin
        o_level[p] = i_out[p];
      end else if (i_ext_en[p]) begin
        o_level[p] = i_ext_val[p];
      end else begin
        o_level[p] = ~i_pd[p];
      end
    end
  end
endmodule
